//--- include/mmi_consts.vh
// Constants for the module management interface block
`ifndef MMI_CONSTS_VH
`define MMI_CONSTS_VH

// Two-wire device address, upper seven bits of the A0 byte
`define MMI_DEV_ADDR        7'h50
// Lower page layout
`define MMI_FLAG_FIRST      8'h03
`define MMI_FLAG_LAST       8'h11
`define MMI_RO_LAST         8'h4F
`define MMI_CTRL_FIRST      8'h50
`define MMI_CTRL_LAST       8'h65
`define MMI_MASK_FIRST      8'h66
`define MMI_MASK_LAST       8'h74
`define MMI_PASS_FIRST      8'h77
`define MMI_PASS_LAST       8'h7E
`define MMI_PAGE_SEL        8'h7F
`define MMI_UPPER_BASE      8'h80
// Control byte 93 bit 0 requests high power in software mode
`define MMI_PWR_CTRL        8'h5D
`define MMI_PWR_BIT         0
// Page index width (eight pages held in the memory)
`define MMI_PAGE_W          3
`define MMI_MEM_AW          11
// Reset pulse minimum, ns, and clock period, ns
`define MMI_RESET_MIN_NS    2000
`define MMI_CLK_NS          40
// Settling time after reset before bus is served, cycles
`define MMI_INIT_CYCLES     8'h10
`define MMI_ZERO8           8'h00

`endif

//--- hw/mmi_mem.v
// Paged management memory with registered read data
`timescale 1ns/1ns
`default_nettype none
`include "mmi_consts.vh"

module mmi_mem (
  input  wire                      clk_i,
  input  wire                      we_i,
  input  wire [`MMI_MEM_AW-1:0]    addr_i,
  input  wire [7:0]                wdata_i,
  output reg  [7:0]                rdata_o
);

  reg [7:0] mem [0:(1<<`MMI_MEM_AW)-1];

  // Single port, write first is not needed here
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end

endmodule // mmi_mem
`default_nettype wire

//--- hw/mmi_top.v
// Two-wire management slave with lower page, paging and flag interrupt
`timescale 1ns/1ns
`default_nettype none
`include "mmi_consts.vh"

module mmi_top (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        scl_i,
  input  wire        sda_i,
  output reg         sda_o,
  output reg         sda_oe_o,
  input  wire        module_select_n_i,
  input  wire        module_reset_n_i,
  input  wire        init_software_control_i,
  input  wire        legacy_low_power_pin_i,
  input  wire [119:0] flag_event_i,
  output reg         module_present_n_o,
  output reg         interrupt_n_o,
  output reg         high_power_o,
  output reg         mgmt_ready_o
);

  // ****************************************************************
  // Constants and functions
  // ****************************************************************
  localparam [15:0] RST_CYC = (`MMI_RESET_MIN_NS + `MMI_CLK_NS - 1) / `MMI_CLK_NS;

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_AACK = 3'h2;
  localparam [2:0] ST_WBYT = 3'h3;
  localparam [2:0] ST_WACK = 3'h4;
  localparam [2:0] ST_RBYT = 3'h5;
  localparam [2:0] ST_RACK = 3'h6;

  // Byte offset classes
  function is_flag;
    input [7:0] a;
    is_flag = (a >= `MMI_FLAG_FIRST) && (a <= `MMI_FLAG_LAST);
  endfunction

  function is_writable;
    input [7:0] a;
    is_writable = (a >= `MMI_UPPER_BASE) || (a == `MMI_PAGE_SEL) ||
                  ((a >= `MMI_CTRL_FIRST) && (a <= `MMI_PASS_LAST));
  endfunction

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  reg [1:0] scl_s;
  reg [1:0] sda_s;
  reg [1:0] sel_s;
  reg [1:0] rstn_s;
  reg [1:0] init_s;
  reg [1:0] lp_s;
  reg       scl_d;
  reg       sda_d;

  // Two stages for the bus pins and the four module control pins, flag events unsynchronised, then one history stage for edges
  always @(posedge clk_i) begin
    scl_s  <= {scl_s[0], scl_i};
    sda_s  <= {sda_s[0], sda_i};
    sel_s  <= {sel_s[0], module_select_n_i};
    rstn_s <= {rstn_s[0], module_reset_n_i};
    init_s <= {init_s[0], init_software_control_i};
    lp_s   <= {lp_s[0], legacy_low_power_pin_i};
    scl_d  <= scl_s[1];
    sda_d  <= sda_s[1];
  end

  wire scl_rise = scl_s[1] & ~scl_d;
  wire scl_fall = ~scl_s[1] & scl_d;
  wire start_c  = scl_s[1] & scl_d & sda_d & ~sda_s[1];
  wire stop_c   = scl_s[1] & scl_d & ~sda_d & sda_s[1];

  // ****************************************************************
  // Module reset pin and initialisation
  // ****************************************************************
  reg [15:0] rst_cnt;
  reg        pin_reset;
  reg [7:0]  init_cnt;

  // Pulse must exceed the minimum; glitches are filtered by count
  always @(posedge clk_i) begin
    if (rst_i) begin
      rst_cnt   <= 16'h0000;
      pin_reset <= 1'b1;
      init_cnt  <= `MMI_ZERO8;
    end else begin
      if (rstn_s[1]) begin
        rst_cnt <= 16'h0000;
      end else if (rst_cnt != RST_CYC) begin
        rst_cnt <= rst_cnt + 16'h0001;
      end
      if (!rstn_s[1] && rst_cnt == RST_CYC) begin
        pin_reset <= 1'b1;
        init_cnt  <= `MMI_ZERO8;
      end else if (init_cnt != `MMI_INIT_CYCLES) begin
        init_cnt <= init_cnt + 8'h01;
      end else begin
        pin_reset <= 1'b0;
      end
    end
  end

  wire busy = pin_reset;

  // ****************************************************************
  // Serial slave state machine
  // ****************************************************************
  reg [2:0]  state;
  reg [7:0]  shift;
  reg [3:0]  bitc;
  reg        rd_mode;
  reg        first_wr;
  reg        wr_adv;
  reg [7:0]  offset;
  reg [`MMI_PAGE_W-1:0] page;
  reg        mem_we;
  reg [7:0]  mem_wd;
  reg [119:0] flags;
  reg [119:0] masks;
  reg [7:0]  pwr_ctrl;
  reg        drive_low;
  reg        rd_clr;
  reg [7:0]  rd_clr_off;
  wire [7:0] mem_rd;
  wire [7:0] next_offset = {offset[7], offset[6:0] + 7'h01};   // Wraps inside the page half

  // Lower page lives at page slot zero; upper bytes follow the page select
  wire [`MMI_MEM_AW-1:0] mem_addr = offset[7] ?
         {page, offset} : {{`MMI_PAGE_W{1'b0}}, offset};

  // Read data: flags, masks, page select and power control from registers, password area zero, rest from memory
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = mem_rd;
    if (is_flag(offset)) begin
      rd_byte = flags[(offset - `MMI_FLAG_FIRST)*8 +: 8];
    end else if (offset >= `MMI_MASK_FIRST && offset <= `MMI_MASK_LAST) begin
      rd_byte = masks[(offset - `MMI_MASK_FIRST)*8 +: 8];
    end else if (offset == `MMI_PAGE_SEL) begin
      rd_byte = {{(8-`MMI_PAGE_W){1'b0}}, page};
    end else if (offset == `MMI_PWR_CTRL) begin
      rd_byte = pwr_ctrl;
    end else if (offset >= `MMI_PASS_FIRST && offset <= `MMI_PASS_LAST) begin
      rd_byte = `MMI_ZERO8;                                // write-only area
    end
  end

  // Bit engine, acknowledge and pointer handling
  always @(posedge clk_i) begin
    if (rst_i || busy) begin
      state     <= ST_IDLE;
      shift     <= `MMI_ZERO8;
      bitc      <= 4'h0;
      rd_mode   <= 1'b0;
      first_wr  <= 1'b0;
      wr_adv    <= 1'b0;
      offset    <= `MMI_ZERO8;
      page      <= {`MMI_PAGE_W{1'b0}};
      masks     <= 120'h0;
      pwr_ctrl  <= `MMI_ZERO8;
      mem_we    <= 1'b0;
      mem_wd    <= `MMI_ZERO8;
      drive_low <= 1'b0;
      rd_clr    <= 1'b0;
      rd_clr_off <= `MMI_ZERO8;
    end else begin
      mem_we <= 1'b0;
      rd_clr <= 1'b0;
      if (sel_s[1]) begin
        state     <= ST_IDLE;
        drive_low <= 1'b0;
      end else if (start_c) begin
        state     <= ST_ADDR;
        bitc      <= 4'h0;
        drive_low <= 1'b0;
      end else if (stop_c) begin
        state     <= ST_IDLE;
        drive_low <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_WBYT: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda_s[1]};
              bitc  <= bitc + 4'h1;
            end else if (scl_fall && bitc == 4'h8) begin
              bitc <= 4'h0;
              if (state == ST_ADDR) begin
                if (shift[7:1] == `MMI_DEV_ADDR) begin
                  drive_low <= 1'b1;
                  rd_mode   <= shift[0];
                  first_wr  <= ~shift[0];
                  state     <= ST_AACK;
                end else begin
                  state <= ST_IDLE;
                end
              end else begin
                drive_low <= 1'b1;
                state     <= ST_WACK;
                wr_adv    <= ~first_wr;
                if (first_wr) begin
                  offset   <= shift;
                  first_wr <= 1'b0;
                end else begin
                  if (is_writable(offset)) begin
                    if (offset == `MMI_PAGE_SEL) begin
                      page <= shift[`MMI_PAGE_W-1:0];
                    end else if (offset >= `MMI_MASK_FIRST && offset <= `MMI_MASK_LAST) begin
                      masks[(offset - `MMI_MASK_FIRST)*8 +: 8] <= shift;
                    end else if (offset == `MMI_PWR_CTRL) begin
                      pwr_ctrl <= shift;
                    end else begin
                      mem_we <= 1'b1;
                      mem_wd <= shift;
                    end
                  end
                end
              end
            end
          end
          ST_AACK, ST_WACK: begin
            if (scl_fall) begin
              drive_low <= 1'b0;
              offset    <= (state == ST_WACK && wr_adv) ? next_offset : offset;
              if (rd_mode) begin
                state     <= ST_RBYT;
                shift     <= rd_byte;
                drive_low <= ~rd_byte[7];
                bitc      <= 4'h1;
                rd_clr     <= is_flag(offset);
                rd_clr_off <= offset;
              end else begin
                state <= ST_WBYT;
              end
            end
          end
          ST_RBYT: begin
            if (scl_fall) begin
              if (bitc == 4'h8) begin
                drive_low <= 1'b0;
                bitc      <= 4'h0;
                state     <= ST_RACK;
                offset    <= next_offset;
              end else begin
                drive_low <= ~shift[7 - bitc[2:0]];
                bitc      <= bitc + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              state <= sda_s[1] ? ST_IDLE : ST_AACK;  // Host nack ends read
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // Latched flags, clear on read with set winning
  // ****************************************************************
  wire [119:0] clr_mask = rd_clr ?
         ({112'h0, 8'hFF} << ((rd_clr_off - `MMI_FLAG_FIRST) * 8)) : 120'h0;

  always @(posedge clk_i) begin
    if (rst_i || busy) begin
      flags <= 120'h0;
    end else begin
      flags <= (flags & ~clr_mask) | flag_event_i;
    end
  end

  mmi_mem u_mem (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .addr_i  (mem_addr),
    .wdata_i (mem_wd),
    .rdata_o (mem_rd)
  );

  // ****************************************************************
  // Pin outputs
  // ****************************************************************
  // Interrupt follows unmasked flags, so it drops two cycles after the flag byte is read
  always @(posedge clk_i) begin
    if (rst_i) begin
      sda_o              <= 1'b0;
      sda_oe_o           <= 1'b0;
      module_present_n_o <= 1'b0;
      interrupt_n_o      <= 1'b1;
      high_power_o       <= 1'b0;
      mgmt_ready_o       <= 1'b0;
    end else begin
      sda_o              <= 1'b0;
      sda_oe_o           <= drive_low & ~sel_s[1] & ~busy;
      module_present_n_o <= 1'b0;
      interrupt_n_o      <= busy | ~(|(flags & ~masks));
      mgmt_ready_o       <= ~busy;
      if (busy) begin
        high_power_o <= 1'b0;
      end else if (init_s[1]) begin
        high_power_o <= pwr_ctrl[`MMI_PWR_BIT] & ~lp_s[1];
      end else begin
        high_power_o <= 1'b1;
      end
    end
  end

endmodule // mmi_top
`default_nettype wire

//--- dv/mmi_top_sva.sv
// Port checker for the module management interface block
`timescale 1ns/1ns
`default_nettype none
// ****************
// Checker
// ****************
module mmi_top_sva (
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire logic         scl_i,
  input wire logic         sda_i,
  input wire logic         sda_o,
  input wire logic         sda_oe_o,
  input wire logic         module_select_n_i,
  input wire logic         module_reset_n_i,
  input wire logic         init_software_control_i,
  input wire logic         legacy_low_power_pin_i,
  input wire logic [119:0] flag_event_i,
  input wire logic         module_present_n_o,
  input wire logic         interrupt_n_o,
  input wire logic         high_power_o,
  input wire logic         mgmt_ready_o
);
  logic [5:0] low_cnt;
  logic [4:0] since_evt;
  // Saturating counts, so long waits need no long repetition
  always @(posedge clk_i) begin
    if (rst_i) begin
      low_cnt   <= 6'h00;
      since_evt <= 5'h1F;
    end else begin
      low_cnt   <= module_reset_n_i ? 6'h00 : low_cnt + {5'h00, low_cnt != 6'h3F};
      since_evt <= (|flag_event_i) ? 5'h00 : since_evt + {4'h0, since_evt != 5'h1F};
    end
  end
  default clocking mmi_cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_desel_quiet: assert property (module_select_n_i [*4] |-> !sda_oe_o)
    else $error("data pin pulled while deselected");
  a_ready_gate: assert property (!mgmt_ready_o |-> !sda_oe_o)
    else $error("data pin pulled before ready");
  a_scl_low_only: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data pin changed while clock high");
  a_pin_reset_quiet: assert property (low_cnt >= 6'h36 |-> !sda_oe_o && interrupt_n_o)
    else $error("activity during pin reset");
  a_long_reset: assert property (low_cnt == 6'h32 |-> ##[0:4] !high_power_o)
    else $error("power kept over long reset");
  a_lp_pin_low: assert property ((init_software_control_i && legacy_low_power_pin_i) [*4] |-> !high_power_o)
    else $error("high power with low power pin");
  a_hw_power_up: assert property ($rose(mgmt_ready_o) && !init_software_control_i |-> ##[0:100] high_power_o)
    else $error("no high power in hardware mode");
  a_present_low: assert property (!module_present_n_o)
    else $error("present output high");
  a_int_cause: assert property ($fell(interrupt_n_o) |-> since_evt < 5'h1F)
    else $error("interrupt without flag event");
  c_int: cover property ($fell(interrupt_n_o));
  c_power: cover property ($rose(high_power_o));
  c_ack: cover property ($rose(sda_oe_o));
endmodule // mmi_top_sva
bind mmi_top mmi_top_sva u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .module_select_n_i(module_select_n_i),
  .module_reset_n_i(module_reset_n_i), .init_software_control_i(init_software_control_i),
  .legacy_low_power_pin_i(legacy_low_power_pin_i), .flag_event_i(flag_event_i),
  .module_present_n_o(module_present_n_o), .interrupt_n_o(interrupt_n_o),
  .high_power_o(high_power_o), .mgmt_ready_o(mgmt_ready_o));
`default_nettype wire

//--- dv/mmi_host.sv
// Two-wire host controller model for the bench
`timescale 1ns/1ns
`default_nettype none
module mmi_host (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic pull_o
);
  // Bus idles with the clock driven high and the data line released to the pull-up
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Eight cycles per phase so the device's two-stage sync keeps up
  task automatic bitx(input logic b, output logic r);
    hold(4);
    pull_o = ~b;
    hold(4);
    scl_o = 1'b1;
    hold(4);
    r = sda_i;
    hold(4);
    scl_o = 1'b0;
  endtask
  task automatic start();
    pull_o = 1'b1;
    hold(8);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    hold(4);
    pull_o = 1'b1;
    hold(4);
    scl_o = 1'b1;
    hold(8);
    pull_o = 1'b0;
    hold(8);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  // Last byte refused with a released ack bit to end the read
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(last, r);
  endtask
endmodule // mmi_host
`default_nettype wire

//--- dv/mmi_top_tb.sv
// Self-checking bench for the module management interface block
`timescale 1ns/1ns
`default_nettype none
module mmi_top_tb;
  typedef struct { string nm; logic [7:0] v; } mmi_note_t;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         sel_n = 1'b1;
  logic         rstp_n = 1'b1;
  logic         init_sw = 1'b1;
  logic         lp_pin = 1'b0;
  logic [119:0] flags = 120'h0;
  logic         scl, pull, sda, sda_o, sda_oe, prs_n;
  wire  [2:0]   st;
  logic [31:0]  seed = 32'hD63A07DD;
  logic [31:0]  d;
  logic [7:0]   obs;
  mmi_note_t    exp_q[$];
  mmi_note_t    nt;
  event         obs_ev;
  int           n_errors = 0;
  int           checks = 0;
  int           fi, fb;
  initial forever #20 clk_i = ~clk_i;
  // Released line reads high through the pull-up
  assign sda = (pull || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;
  mmi_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .module_select_n_i(sel_n), .module_reset_n_i(rstp_n),
    .init_software_control_i(init_sw), .legacy_low_power_pin_i(lp_pin),
    .flag_event_i(flags), .module_present_n_o(prs_n), .interrupt_n_o(st[1]),
    .high_power_o(st[2]), .mgmt_ready_o(st[0]));
  mmi_host u_host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .pull_o(pull));
  // ****************
  // Checking
  // ****************
  initial forever begin
    @(obs_ev);
    nt = exp_q.pop_front();
    checks++;
    if (obs !== nt.v) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nt.nm, nt.v, obs);
    end
  end
  task automatic note(input string nm, input logic [7:0] e, input logic [7:0] s);
    exp_q.push_back('{nm, e});
    obs = s;
    -> obs_ev;
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Bounded wait on ready (0), interrupt (1) or power (2)
  task automatic wait_for(input string nm, input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (st[k] !== v && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    if (st[k] !== v) begin
      n_errors++;
      wrap_up();
    end
    note(nm, {7'h00, v}, {7'h00, st[k]});
  endtask
  // ****************
  // Bus transfers
  // ****************
  task automatic wr(input logic [7:0] off, input int n, input logic [15:0] dv);
    logic [2:0] a;
    u_host.start();
    u_host.wbyte(8'hA0, a[0]);
    u_host.wbyte(off, a[1]);
    for (int i = n - 1; i >= 0; i--) u_host.wbyte(dv[i*8 +: 8], a[2]);
    u_host.stop();
    note("write ack", 8'h07, {5'h00, a});
  endtask
  task automatic rd(input logic [7:0] off, input int n, input logic [15:0] e);
    logic [2:0] a;
    logic [7:0] b;
    u_host.start();
    u_host.wbyte(8'hA0, a[0]);
    u_host.wbyte(off, a[1]);
    u_host.stop();
    u_host.start();
    u_host.wbyte(8'hA1, a[2]);
    note("read ack", 8'h07, {5'h00, a});
    for (int i = n - 1; i >= 0; i--) begin
      u_host.rbyte(i == 0, b);
      note("read data", e[i*8 +: 8], b);
    end
    u_host.stop();
  endtask
  task automatic probe(input logic [7:0] adr, input logic e);
    logic a;
    u_host.start();
    u_host.wbyte(adr, a);
    u_host.stop();
    note("address ack", {7'h00, e}, {7'h00, a});
  endtask
  task automatic sel(input logic v);
    sel_n = v;
    repeat (50) @(negedge clk_i);
  endtask
  task automatic pulse();
    flags[fi*8+fb] = 1'b1;
    @(negedge clk_i);
    flags = 120'h0;
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    note("present", 8'h00, {7'h00, prs_n});
    wait_for("ready", 0, 1'b1, 200);
    note("low power", 8'h00, {7'h00, st[2]});
    sel(1'b0);
    d = rnd();
    wr(8'h66, 2, d[15:0]);
    rd(8'h66, 2, d[15:0]);
    wr(8'h04, 1, 16'h00FF);
    rd(8'h04, 1, 16'h0000);
    wr(8'h77, 1, d[15:0]);
    rd(8'h77, 1, 16'h0000);
    $display("test regions done");
    probe(8'hA2, 1'b0);
    sel(1'b1);
    probe(8'hA0, 1'b0);
    sel(1'b0);
    probe(8'hA0, 1'b1);
    $display("test addressing done");
    wr(8'h7F, 1, 16'h0002);
    wr(8'h80, 1, {8'h00, d[23:16]});
    wr(8'h7F, 1, 16'h0003);
    wr(8'hE0, 1, {8'h00, d[31:24]});
    wr(8'h7F, 1, 16'h0002);
    rd(8'h80, 1, {8'h00, d[23:16]});
    $display("test paging done");
    fi = rnd() % 15;
    fb = rnd() % 8;
    wr(8'(8'h66 + fi), 1, 16'h0000);
    pulse();
    wait_for("int set", 1, 1'b0, 1000);
    rd(8'(3 + fi), 1, {8'h00, 8'h01 << fb});
    wait_for("int clear", 1, 1'b1, 12500);
    rd(8'(3 + fi), 1, 16'h0000);
    wr(8'(8'h66 + fi), 1, {8'h00, 8'h01 << fb});
    pulse();
    repeat (100) @(negedge clk_i);
    note("masked int", 8'h01, {7'h00, st[1]});
    rd(8'(3 + fi), 1, {8'h00, 8'h01 << fb});
    $display("test interrupts done");
    wr(8'h5D, 1, 16'h0001);
    wait_for("power on", 2, 1'b1, 200);
    lp_pin = 1'b1;
    wait_for("pin low power", 2, 1'b0, 50);
    lp_pin = 1'b0;
    wait_for("power back", 2, 1'b1, 50);
    $display("test power done");
    rstp_n = 1'b0;
    repeat (60) @(negedge clk_i);
    probe(8'hA0, 1'b0);
    rstp_n = 1'b1;
    wait_for("ready again", 0, 1'b1, 200);
    note("reset power", 8'h00, {7'h00, st[2]});
    rd(8'h7F, 1, 16'h0000);
    $display("test pin reset done");
    // Fresh power-up stands for a new insertion in hardware mode
    rst_i = 1'b1;
    init_sw = 1'b0;
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    wait_for("hw power", 2, 1'b1, 500);
    $display("test hardware mode done");
    wrap_up();
  end
endmodule // mmi_top_tb
`default_nettype wire
